// file: logic/idg_pkg.sv
// Shared constants and carrier types for the delta velocity and gyro bias register block.
package idg_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************

  // One register word, as seen by the host.
  localparam int unsigned IDG_WORD_W = 16;
  // One combined two-word value.
  localparam int unsigned IDG_AXIS_W = 32;
  // Byte address width of the register port.
  localparam int unsigned IDG_ADDR_W = 7;

  // ********************************************************************
  // Register byte addresses
  // ********************************************************************

  // Each register spans two bytes; the odd byte selects the same word.
  localparam logic [6:0] IDG_ADDR_ZVEL_LOW = 7'h38;
  localparam logic [6:0] IDG_ADDR_ZVEL_HIGH = 7'h3a;
  localparam logic [6:0] IDG_ADDR_RATE_X_LOW = 7'h40;
  localparam logic [6:0] IDG_ADDR_RATE_X_HIGH = 7'h42;
  localparam logic [6:0] IDG_ADDR_RATE_Y_LOW = 7'h44;
  localparam logic [6:0] IDG_ADDR_RATE_Y_HIGH = 7'h46;
  localparam logic [6:0] IDG_ADDR_RATE_Z_LOW = 7'h48;
  localparam logic [6:0] IDG_ADDR_RATE_Z_HIGH = 7'h4a;

  // ********************************************************************
  // Reset and answer values
  // ********************************************************************

  // Reset value of every bias word.
  localparam logic [15:0] IDG_BIAS_RESET = 16'h0000;
  // Word returned for an address outside this block.
  localparam logic [15:0] IDG_UNMAPPED_DATA = 16'h0000;
  // Reset value of the velocity snapshot, which has no defined value for software.
  localparam logic [31:0] IDG_ZVEL_RESET = 32'h0000_0000;

  // ********************************************************************
  // Timing
  // ********************************************************************

  // Core clock rate in hertz.
  localparam int unsigned IDG_CLK_HZ = 100_000_000;
  // Internal processing rate of the compensated signal chain in hertz.
  localparam int unsigned IDG_PROC_HZ = 2000;
  // Clock cycles between two processing ticks.
  localparam int unsigned IDG_PROC_CYCLES = IDG_CLK_HZ / IDG_PROC_HZ;
  // Width of the tick counter.
  localparam int unsigned IDG_TICK_W = 16;

  // ********************************************************************
  // Carrier types
  // ********************************************************************

  // One host register access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } idg_reg_req_t;

  // One signed 32-bit value for each gyro axis.
  typedef struct packed {
    logic signed [31:0] x;
    logic signed [31:0] y;
    logic signed [31:0] z;
  } idg_axes_t;

endpackage : idg_pkg

// file: logic/idg_bias_add.sv
// Saturating signed adder that applies one axis bias to one compensated sample.
`timescale 1ns/1ns
module idg_bias_add (
  // Operands.
  input wire logic signed [31:0] sample_i,
  input wire logic signed [31:0] bias_i,
  // Result.
  output logic signed [31:0] sum_o
);

  // ********************************************************************
  // Addition
  // ********************************************************************

  // One guard bit shows an overflow of the 32-bit range.
  logic signed [32:0] wide;

  // Saturate rather than wrap, so a large bias never flips the sign of the rate.
  always_comb begin
    wide = 33'(sample_i) + 33'(bias_i);
    if (wide[32] != wide[31]) begin
      // Overflow: clamp to the end of the range on the true sign.
      sum_o = wide[32] ? 32'sh8000_0000 : 32'sh7fff_ffff;
    end else begin
      // In range: keep the plain two's complement sum.
      sum_o = wide[31:0];
    end
  end

endmodule : idg_bias_add

// file: logic/idg_regs.sv
// Z-axis delta velocity output words and user gyro bias registers with bias application.
//
// Function
// - Velocity upper word: read-only 16-bit two's complement.
// - Lower word extends velocity to 32 bits.
// - Velocity words at 0x38, 0x3A, read-only.
// - 16-bit view: signed code passed unchanged.
// - 32-bit view: signed code passed unchanged.
// - Apply bias at 2000 Hz processing tick.
// - Factory coefficients never reachable by host.
// - X bias words at 0x40 and 0x42.
// - Y bias words at 0x44 and 0x46.
// - Z bias words at 0x48 and 0x4A.
// - Bias words read/write, reset zero, restorable.
// - Bias upper word scaled like rate word.
// - Combined bias encoded like 32-bit rate.
`timescale 1ns/1ns
module idg_regs #(
  // Cycles between processing ticks; shorten for simulation.
  parameter int unsigned PROC_CYCLES = idg_pkg::IDG_PROC_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host register port.
  input wire idg_pkg::idg_reg_req_t reg_req_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // Factory-compensated gyro samples and the z delta velocity result.
  input wire idg_pkg::idg_axes_t gyro_raw_i,
  input wire logic [31:0] zvel_i,
  input wire logic zvel_valid_i,
  // Restore path from the backup store.
  input wire logic restore_i,
  input wire idg_pkg::idg_axes_t restore_data_i,
  // Corrected rates and the bias values for backup.
  output idg_pkg::idg_axes_t rate_o,
  output logic rate_valid_o,
  output idg_pkg::idg_axes_t bias_o
);

  // ********************************************************************
  // State
  // ********************************************************************

  // Last tick counter value before it wraps.
  localparam logic [15:0] TICK_LAST = 16'(PROC_CYCLES - 1);

  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    idg_pkg::idg_axes_t bias;
    idg_pkg::idg_axes_t rate;
    logic rate_valid;
    logic [31:0] zvel;
    logic [15:0] rdata;
    logic rdata_valid;
    logic [15:0] tick_cnt;
  } idg_state_t;

  // Registered state and its next value.
  idg_state_t state_reg;
  idg_state_t state_next;
  // Processing tick, high for one cycle every PROC_CYCLES cycles.
  logic tick;
  // Biased samples from the three adders, one net each so every adder has a driver of its own.
  logic signed [31:0] sum_x;
  logic signed [31:0] sum_y;
  logic signed [31:0] sum_z;
  // The three biased samples gathered for the rate register.
  idg_pkg::idg_axes_t sum;

  // Register word selected by the byte address; the low address bit is ignored.
  function automatic logic hit(input logic [6:0] addr, input logic [6:0] offset);
    hit = (addr[6:1] == offset[6:1]);
  endfunction : hit

  // ********************************************************************
  // Bias adders
  // ********************************************************************

  // The tick is a decode of the free-running counter.
  assign tick = (state_reg.tick_cnt == TICK_LAST);

  // X axis adder.
  idg_bias_add u_add_x (
    .sample_i(gyro_raw_i.x),
    .bias_i(state_reg.bias.x),
    .sum_o(sum_x)
  );

  // Y axis adder.
  idg_bias_add u_add_y (
    .sample_i(gyro_raw_i.y),
    .bias_i(state_reg.bias.y),
    .sum_o(sum_y)
  );

  // Z axis adder.
  idg_bias_add u_add_z (
    .sample_i(gyro_raw_i.z),
    .bias_i(state_reg.bias.z),
    .sum_o(sum_z)
  );

  // Pack the three sums in axis order, x in the top word as in the carrier type.
  assign sum = {sum_x, sum_y, sum_z};

  // ********************************************************************
  // Next state
  // ********************************************************************

  // All updates of the block are worked out here in one pass.
  always_comb begin
    state_next = state_reg;
    state_next.rdata_valid = 1'b0;
    state_next.rate_valid = 1'b0;
    // Free-running processing counter.
    if (tick) begin
      state_next.tick_cnt = 16'h0000;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 16'h0001;
    end
    // The bias follows the factory stage, once per processing tick.
    if (tick) begin
      state_next.rate = sum;
      state_next.rate_valid = 1'b1;
    end
    // Keep the newest velocity result; its code is passed through unchanged.
    if (zvel_valid_i) begin
      state_next.zvel = zvel_i;
    end
    // A restore loads all bias words; a host write in the same cycle wins below.
    if (restore_i) begin
      state_next.bias = restore_data_i;
    end
    // Host writes reach only the bias words; velocity words ignore writes.
    if (reg_req_i.wr) begin
      if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_LOW)) begin
        state_next.bias.x[15:0] = reg_req_i.wdata;
      end
      if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_HIGH)) begin
        state_next.bias.x[31:16] = reg_req_i.wdata;
      end
      if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_LOW)) begin
        state_next.bias.y[15:0] = reg_req_i.wdata;
      end
      if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_HIGH)) begin
        state_next.bias.y[31:16] = reg_req_i.wdata;
      end
      if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_LOW)) begin
        state_next.bias.z[15:0] = reg_req_i.wdata;
      end
      if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_HIGH)) begin
        state_next.bias.z[31:16] = reg_req_i.wdata;
      end
    end
    // A read answers on the next edge from the current register contents.
    if (reg_req_i.rd) begin
      state_next.rdata_valid = 1'b1;
      if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_ZVEL_LOW)) begin
        state_next.rdata = state_reg.zvel[15:0];
      end else if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_ZVEL_HIGH)) begin
        state_next.rdata = state_reg.zvel[31:16];
      end else if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_LOW)) begin
        state_next.rdata = state_reg.bias.x[15:0];
      end else if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_HIGH)) begin
        state_next.rdata = state_reg.bias.x[31:16];
      end else if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_LOW)) begin
        state_next.rdata = state_reg.bias.y[15:0];
      end else if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_HIGH)) begin
        state_next.rdata = state_reg.bias.y[31:16];
      end else if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_LOW)) begin
        state_next.rdata = state_reg.bias.z[15:0];
      end else if (hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_HIGH)) begin
        state_next.rdata = state_reg.bias.z[31:16];
      end else begin
        // Nothing else is mapped here, so no calibration internals can leak out.
        state_next.rdata = idg_pkg::IDG_UNMAPPED_DATA;
      end
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************

  // Reset clears the bias words; the velocity snapshot resets only for determinism.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg.bias <= {3{idg_pkg::IDG_BIAS_RESET, idg_pkg::IDG_BIAS_RESET}};
      state_reg.rate <= '0;
      state_reg.rate_valid <= 1'b0;
      state_reg.zvel <= idg_pkg::IDG_ZVEL_RESET;
      state_reg.rdata <= 16'h0000;
      state_reg.rdata_valid <= 1'b0;
      state_reg.tick_cnt <= 16'h0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************

  // Every output is a field of the state register.
  assign rd_data_o = state_reg.rdata;
  assign rd_valid_o = state_reg.rdata_valid;
  assign rate_o = state_reg.rate;
  assign rate_valid_o = state_reg.rate_valid;
  assign bias_o = state_reg.bias;

  // ********************************************************************
  // Assertions
  // ********************************************************************

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // A write to the x low word lands in the bias on the next edge.
  a_write_x_low: assert property (
    reg_req_i.wr && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_LOW)
    |=> bias_o.x[15:0] == $past(reg_req_i.wdata))
    else $error("x bias low word not written");

  // A write to the y high word lands in the bias on the next edge.
  a_write_y_high: assert property (
    reg_req_i.wr && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_HIGH)
    |=> bias_o.y[31:16] == $past(reg_req_i.wdata))
    else $error("y bias high word not written");

  // A write to the z low word leaves the z high word alone.
  a_write_z_low: assert property (
    reg_req_i.wr && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_LOW) && !restore_i
    |=> bias_o.z[15:0] == $past(reg_req_i.wdata) && $stable(bias_o.z[31:16]))
    else $error("z bias low word write wrong");

  // Reading the x high word returns what the bias held at the request.
  a_read_bias_back: assert property (
    reg_req_i.rd && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_HIGH)
    |=> rd_valid_o && rd_data_o == $past(bias_o.x[31:16]))
    else $error("x bias high word read back wrong");

  // The velocity upper word reads as the top half of the snapshot.
  a_read_vel_high: assert property (
    reg_req_i.rd && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_ZVEL_HIGH)
    |=> rd_valid_o && rd_data_o == $past(state_reg.zvel[31:16]))
    else $error("velocity upper word read wrong");

  // The velocity lower word reads as the bottom half of the snapshot.
  a_read_vel_low: assert property (
    reg_req_i.rd && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_ZVEL_LOW)
    |=> rd_data_o == $past(state_reg.zvel[15:0]))
    else $error("velocity lower word read wrong");

  // Host writes never alter the velocity snapshot.
  a_vel_read_only: assert property (
    reg_req_i.wr && !zvel_valid_i |=> $stable(state_reg.zvel))
    else $error("velocity word changed by a write");

  // Reads outside the eight mapped words answer with the fixed unmapped word.
  a_unmapped_zero: assert property (
    reg_req_i.rd
    && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_ZVEL_LOW) && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_ZVEL_HIGH)
    && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_LOW) && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_HIGH)
    && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_LOW) && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_HIGH)
    && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_LOW) && !hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_HIGH)
    |=> rd_valid_o && rd_data_o == idg_pkg::IDG_UNMAPPED_DATA)
    else $error("unmapped read not zero");

  // After a result, no other result appears for the next eight cycles.
  a_tick_spacing: assert property (
    rate_valid_o |=> !rate_valid_o [*8])
    else $error("processing ticks too close");

  // An x result from a zero x sample equals the x bias held at the tick.
  a_bias_applied: assert property (
    rate_valid_o && $past(gyro_raw_i.x) == 32'sh0000_0000
    |-> rate_o.x == $past(state_reg.bias.x))
    else $error("bias not applied to x rate");

  // A write to the x high word lands in the bias on the next edge.
  a_write_x_high: assert property (
    reg_req_i.wr && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_X_HIGH)
    |=> bias_o.x[31:16] == $past(reg_req_i.wdata))
    else $error("x bias high word not written");

  // A write to the y low word lands in the bias on the next edge.
  a_write_y_low: assert property (
    reg_req_i.wr && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Y_LOW)
    |=> bias_o.y[15:0] == $past(reg_req_i.wdata))
    else $error("y bias low word not written");

  // A write to the z high word lands in the bias on the next edge.
  a_write_z_high: assert property (
    reg_req_i.wr && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_HIGH)
    |=> bias_o.z[31:16] == $past(reg_req_i.wdata))
    else $error("z bias high word not written");

  // A restore with no host write loads all three axes at once.
  a_restore_load: assert property (
    restore_i && !reg_req_i.wr
    |=> bias_o == $past(restore_data_i))
    else $error("restore did not load the bias");

  // Every read is answered on the next edge.
  a_read_answer: assert property (
    reg_req_i.rd
    |=> rd_valid_o)
    else $error("read not answered");

  // No answer appears without a read before it.
  a_no_stray_valid: assert property (
    !reg_req_i.rd
    |=> !rd_valid_o)
    else $error("answer without a read");

  // A new velocity result is kept whole on the next edge.
  a_vel_load: assert property (
    zvel_valid_i
    |=> state_reg.zvel == $past(zvel_i))
    else $error("velocity result not kept");

  // Reading the z high word returns what the bias held at the request.
  a_read_z_high: assert property (
    reg_req_i.rd && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_HIGH)
    |=> rd_valid_o && rd_data_o == $past(bias_o.z[31:16]))
    else $error("z bias high word read back wrong");

  // A full-scale positive sample with a non-negative bias stays at full scale.
  a_rate_saturate: assert property (
    rate_valid_o && $past(gyro_raw_i.z) == 32'sh7fff_ffff && $past(state_reg.bias.z) >= 0
    |-> rate_o.z == 32'sh7fff_ffff)
    else $error("z rate did not saturate");

  // Between processing ticks the corrected rates hold still.
  a_rate_hold: assert property (
    !rate_valid_o
    |-> $stable(rate_o))
    else $error("rate changed between ticks");

  // Main scenarios.
  c_bias_write: cover property (reg_req_i.wr && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_RATE_Z_HIGH));
  c_vel_read: cover property (reg_req_i.rd && hit(reg_req_i.addr, idg_pkg::IDG_ADDR_ZVEL_HIGH));
  c_rate_out: cover property (rate_valid_o && bias_o.x != 32'sh0000_0000);
  c_restore: cover property (restore_i ##1 reg_req_i.rd);

endmodule : idg_regs

// file: verification/idg_host_model.sv
// Host model that issues register accesses on the block's register port.
`timescale 1ns/1ns
module idg_host_model (
  // Clock.
  input wire logic clk_i,
  // Register port towards the block.
  output idg_pkg::idg_reg_req_t req_o,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i
);
  // The port is idle from time zero so no access is taken during reset.
  initial begin
    req_o = '0;
  end

  // One write; the strobe stands for exactly one taken edge.
  task automatic write_word(input logic [6:0] addr, input logic [15:0] data);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_i);
    req_o.wr <= 1'b0;
    // Released data shows the inverse so a stale value cannot pass for a live one.
    req_o.wdata <= ~data;
  endtask : write_word

  // One read; the answer is looked at just after the taken edge.
  task automatic read_word(input logic [6:0] addr, output logic [15:0] data, output logic ok);
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(posedge clk_i);
    req_o.rd <= 1'b0;
    #1;
    ok = rd_valid_i;
    data = rd_data_i;
  endtask : read_word
endmodule : idg_host_model

// file: verification/test_imu_dvel_gyro_bias_regs.sv
// Self-checking testbench for the delta velocity and gyro bias register block.
`timescale 1ns/1ns
module test_imu_dvel_gyro_bias_regs;
  // Short tick period keeps the run brief; the tick spacing check in t_rate uses it.
  localparam int unsigned TICK = 16;
  localparam logic [6:0] BIAS_ADDR [6] = '{7'h40, 7'h42, 7'h44, 7'h46, 7'h48, 7'h4a};
  logic clk_i;
  logic resetn_i;
  idg_pkg::idg_reg_req_t reg_req;
  logic [15:0] rd_data;
  logic rd_valid;
  idg_pkg::idg_axes_t gyro_raw, restore_data, rate, bias;
  logic [31:0] zvel;
  logic zvel_valid, restore, rate_valid;
  int num_errors = 0;
  int compares = 0;

  // ********************************************************************
  // Clock, design and host
  // ********************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  idg_regs #(.PROC_CYCLES(TICK)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(reg_req),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .gyro_raw_i(gyro_raw), .zvel_i(zvel),
    .zvel_valid_i(zvel_valid), .restore_i(restore), .restore_data_i(restore_data), .rate_o(rate),
    .rate_valid_o(rate_valid), .bias_o(bias));
  idg_host_model u_host (.clk_i(clk_i), .req_o(reg_req), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  // Counts and reports one comparison.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Reads one word and compares it, the answer flag as well.
  task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_host.read_word(addr, d, ok);
    check({31'h0, ok}, 32'h1);
    check({16'h0, d}, {16'h0, exp});
  endtask : rd_chk

  // Waits for the next corrected-rate pulse and returns the cycles spent.
  task automatic wait_rate(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (rate_valid !== 1'b1 && n < 3 * TICK);
  endtask : wait_rate

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  // Every bias word reads zero after reset.
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rd_chk(BIAS_ADDR[i], 16'h0000);
    check(bias.x | bias.y | bias.z, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Writes through the odd byte alias, reads back, and checks word pairing.
  task automatic t_bias_rw;
    for (int i = 0; i < 6; i++) u_host.write_word(BIAS_ADDR[i] | 7'h01, 16'(16'h0101 * (i + 1)));
    for (int i = 0; i < 6; i++) rd_chk(BIAS_ADDR[i], 16'(16'h0101 * (i + 1)));
    check(bias.x, 32'h0202_0101);
    check(bias.y, 32'h0404_0303);
    check(bias.z, 32'h0606_0505);
    $display("test bias_rw done");
  endtask : t_bias_rw

  // Velocity words, a refused write to them, and unmapped places.
  task automatic t_zvel;
    @(posedge clk_i);
    zvel <= 32'h8000_0001;
    zvel_valid <= 1'b1;
    @(posedge clk_i);
    zvel_valid <= 1'b0;
    zvel <= 32'h7fff_fffe;
    rd_chk(7'h3a, 16'h8000);
    rd_chk(7'h38, 16'h0001);
    u_host.write_word(7'h3a, 16'h1234);
    u_host.write_word(7'h3c, 16'h5555);
    rd_chk(7'h3b, 16'h8000);
    rd_chk(7'h3c, 16'h0000);
    check(bias.x, 32'h0202_0101);
    $display("test zvel done");
  endtask : t_zvel

  // Bias is added to each sample at every tick, saturating at full scale.
  task automatic t_rate;
    int n;
    @(posedge clk_i);
    gyro_raw <= '{x: 32'h1000_0000, y: 32'hffff_fff0, z: 32'h7fff_ffff};
    wait_rate(n);
    wait_rate(n);
    check({31'h0, rate_valid}, 32'h1);
    check(rate.x, 32'h1202_0101);
    check(rate.y, 32'h0404_02f3);
    check(rate.z, 32'h7fff_ffff);
    wait_rate(n);
    check(n, TICK);
    $display("test rate done");
  endtask : t_rate

  // Restore from backup loads all three axes at once.
  task automatic t_restore;
    @(posedge clk_i);
    restore_data <= '{x: 32'h1111_2222, y: 32'hfedc_ba98, z: 32'h0000_0007};
    restore <= 1'b1;
    @(posedge clk_i);
    restore <= 1'b0;
    restore_data <= '1;
    #1;
    check(bias.y, 32'hfedc_ba98);
    rd_chk(7'h44, 16'hba98);
    rd_chk(7'h4a, 16'h0000);
    $display("test restore done");
  endtask : t_restore

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // ********************************************************************
  // Main sequence and watchdog
  // ********************************************************************
  initial begin
    resetn_i = 1'b0;
    gyro_raw = '0;
    restore_data = '0;
    zvel = 32'h0;
    zvel_valid = 1'b0;
    restore = 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_bias_rw();
    t_zvel();
    t_rate();
    t_restore();
    close_out();
  end

  // The tests need about a thousand nanoseconds; this margin is generous.
  initial begin
    #100000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
endmodule : test_imu_dvel_gyro_bias_regs
